// ### cam_pkg.sv
// constants, field layout and register map of the counter array mode block
// assumes one system clock and an AHB-Lite register port
//
// Functional notes
// - with modulation on and toggle off, width-select 1 gives 16-bit, 0 gives 8-bit output.
// - match enable sets the module event flag when the running counter equals compare and the comparator is enabled.
// - toggle enable inverts the pin on each match; with modulation: frequency out.
// - modulation enable drives a pulse width modulated waveform on the pin.
// - an event flag requests an interrupt only while the mask bit is 1.
package cam_pkg;
    localparam int NUM_MOD = 3;
    localparam int CNT_W = 16;
    localparam int MODE_W = 8;
    localparam int IDX_W = 10;
    // bit positions inside a module mode register, and BIT_RUN in the control register
    localparam int BIT_WIDE = 7;
    localparam int BIT_CMP_EN = 6;
    localparam int BIT_RISE = 5;
    localparam int BIT_FALL = 4;
    localparam int BIT_MATCH = 3;
    localparam int BIT_TOGGLE = 2;
    localparam int BIT_MOD = 1;
    localparam int BIT_IMASK = 0;
    localparam int BIT_RUN = 0;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
    // register indices; byte address is four times the index
    localparam logic [NUM_MOD-1:0][IDX_W-1:0] IDX_MODE =
        {10'h0DC, 10'h0DB, 10'h0DA};
    localparam logic [NUM_MOD-1:0][IDX_W-1:0] IDX_CMP =
        {10'h0E2, 10'h0E1, 10'h0E0};
    localparam logic [NUM_MOD-1:0][IDX_W-1:0] IDX_CAP =
        {10'h0E6, 10'h0E5, 10'h0E4};
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0D0;
    localparam logic [IDX_W-1:0] IDX_COUNT = 10'h0D1;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0D2;
    localparam logic [IDX_W-1:0] IDX_IMASK = 10'h0D3;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// ### cam_sync.sv
// two-stage synchroniser for the module pins
// assumes the inputs are asynchronous to hclk
`timescale 1ns/100ps
module cam_sync #(
    parameter int W = 3
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cam_sync_s;
    cam_sync_s st_r, st_nxt;

    // first stage feeds only the second stage
    always_comb begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;
endmodule

// ### cam_chan.sv
// one capture/compare module: edge capture, match, toggle, pwm, freq out
// assumes a synchronised pin level and the shared counter on hclk
`timescale 1ns/100ps
module cam_chan
    import cam_pkg::*;
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic run, // counter is advancing
    input wire logic [CNT_W-1:0] cnt, // counter value
    input wire logic [CNT_W-1:0] cmp, // compare value
    input wire logic [MODE_W-1:0] mode, // module mode register
    input wire logic pin_s, // synchronised pin level
    output logic pin_o, // pin drive level, registered
    output logic pin_oe, // pin drive enable, registered
    output logic match_evt, // counter matched compare
    output logic cap_evt // capture edge seen
);
    typedef struct packed {
        logic prev;
        logic pin;
        logic oe;
    } cam_chan_s;
    cam_chan_s st_r, st_nxt;
    logic cmp_on, hit16, hit8, rise, fall;

    assign cmp_on = mode[BIT_CMP_EN];
    assign hit16 = run && (cnt == cmp);
    assign hit8 = run && (cnt[7:0] == cmp[7:0]);
    assign rise = pin_s && !st_r.prev;
    assign fall = !pin_s && st_r.prev;
    assign match_evt = cmp_on && mode[BIT_MATCH] && hit16;
    // capture runs regardless of comparator enable
    assign cap_evt = (rise && mode[BIT_RISE]) || (fall && mode[BIT_FALL]);

    // waveform generation; a disabled comparator freezes the pin level
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pin_s;
        st_nxt.oe = cmp_on && (mode[BIT_TOGGLE] || mode[BIT_MOD]);
        if (cmp_on) begin
            if (mode[BIT_TOGGLE] && mode[BIT_MOD]) begin
                // frequency output toggles on each low-byte match
                if (hit8) begin
                    st_nxt.pin = !st_r.pin;
                end
            end else if (mode[BIT_MOD]) begin
                if (mode[BIT_WIDE]) begin
                    st_nxt.pin = cnt < cmp;
                end else begin
                    st_nxt.pin = cnt[7:0] < cmp[7:0];
                end
            end else if (mode[BIT_TOGGLE] && hit16) begin
                st_nxt.pin = !st_r.pin;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_o = st_r.pin;
    assign pin_oe = st_r.oe;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rise;
        !pin_s ##1 pin_s;
    endsequence
    sequence s_toggle_hit;
        cmp_on && mode[BIT_TOGGLE] && !mode[BIT_MOD] && hit16;
    endsequence

    chk_toggle_flip: assert property (
        s_toggle_hit |=> pin_o != $past(pin_o))
        else $error("toggle mode did not invert the pin on a match");
    chk_pwm_wide: assert property (
        cmp_on && mode[BIT_MOD] && !mode[BIT_TOGGLE] && mode[BIT_WIDE]
        |=> pin_o == $past(cnt < cmp))
        else $error("16-bit pwm level wrong");
    chk_pwm_narrow: assert property (
        cmp_on && mode[BIT_MOD] && !mode[BIT_TOGGLE] && !mode[BIT_WIDE]
        |=> pin_o == $past(cnt[7:0] < cmp[7:0]))
        else $error("8-bit pwm level wrong");
    chk_disable_hold: assert property (
        !cmp_on |=> $stable(pin_o) && !pin_oe)
        else $error("disabled comparator changed the pin");
    chk_capture_rise: assert property (
        (s_rise ##0 mode[BIT_RISE]) |-> cap_evt)
        else $error("rising edge not captured");
endmodule

// ### cam_top.sv
// counter array mode control: three capture/compare modules, a shared
// 16-bit counter, AHB-Lite register slave and one level interrupt
// assumes a single AHB-Lite master and asynchronous module pins
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module cam_top
    import cam_pkg::*;
(
    input wire logic hclk, // system clock, 25 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic [1:0] hresp, // always okay
    input wire logic [NUM_MOD-1:0] module_io_pin_i, // pin levels
    output logic [NUM_MOD-1:0] module_io_pin_o, // pin drive levels
    output logic [NUM_MOD-1:0] module_io_pin_oe, // pin drive enables
    output logic irq // level interrupt
);
    typedef struct packed {
        logic [NUM_MOD-1:0][MODE_W-1:0] mode;
        logic [NUM_MOD-1:0][CNT_W-1:0] cmp;
        logic [NUM_MOD-1:0][CNT_W-1:0] cap;
        logic run;
        logic [CNT_W-1:0] cnt;
        logic [NUM_MOD-1:0] flag;
        logic [NUM_MOD-1:0] imask;
        logic dp_wr;
        logic [IDX_W-1:0] dp_idx;
        logic [31:0] rdata;
        logic irq;
        logic ready;
    } cam_top_s;
    cam_top_s st_r, st_nxt;

    logic [NUM_MOD-1:0] pin_s, match_evt, cap_evt, mod_imask;
    logic addr_ok;
    logic [IDX_W-1:0] a_idx;

    // decoded read of any register word; unmapped reads return zero
    function automatic logic [31:0] rd_word(input cam_top_s s,
                                            input logic [IDX_W-1:0] idx);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < NUM_MOD; i++) begin
            if (idx == IDX_MODE[i]) begin
                w[MODE_W-1:0] = s.mode[i];
            end
            if (idx == IDX_CMP[i]) begin
                w[CNT_W-1:0] = s.cmp[i];
            end
            if (idx == IDX_CAP[i]) begin
                w[CNT_W-1:0] = s.cap[i];
            end
        end
        if (idx == IDX_CTRL) begin
            w[BIT_RUN] = s.run;
        end
        if (idx == IDX_COUNT) begin
            w[CNT_W-1:0] = s.cnt;
        end
        if (idx == IDX_STATUS) begin
            w[NUM_MOD-1:0] = s.flag;
        end
        if (idx == IDX_IMASK) begin
            w[NUM_MOD-1:0] = s.imask;
        end
        return w;
    endfunction

    // pins are asynchronous, so two flops before any logic sees them
    cam_sync #(
        .W(NUM_MOD)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(module_io_pin_i),
        .q(pin_s)
    );

    // one capture/compare module per pin
    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : g_mod
            cam_chan u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .run(st_r.run),
                .cnt(st_r.cnt),
                .cmp(st_r.cmp[g]),
                .mode(st_r.mode[g]),
                .pin_s(pin_s[g]),
                .pin_o(module_io_pin_o[g]),
                .pin_oe(module_io_pin_oe[g]),
                .match_evt(match_evt[g]),
                .cap_evt(cap_evt[g])
            );
            assign mod_imask[g] = st_r.mode[g][BIT_IMASK];
        end
    endgenerate

    assign a_idx = haddr[IDX_W+1:2];
    assign addr_ok = hsel && hready && htrans[1];

    // bus writes land in the data phase, hardware events win over clears
    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = 1'b1;
        if (st_r.run) begin
            st_nxt.cnt = st_r.cnt + CNT_W'(1);
        end
        if (st_r.dp_wr) begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (st_r.dp_idx == IDX_MODE[i]) begin
                    st_nxt.mode[i] = hwdata[MODE_W-1:0];
                end
                if (st_r.dp_idx == IDX_CMP[i]) begin
                    st_nxt.cmp[i] = hwdata[CNT_W-1:0];
                end
            end
            if (st_r.dp_idx == IDX_CTRL) begin
                st_nxt.run = hwdata[BIT_RUN];
            end
            if (st_r.dp_idx == IDX_COUNT) begin
                st_nxt.cnt = hwdata[CNT_W-1:0];
            end
            if (st_r.dp_idx == IDX_IMASK) begin
                st_nxt.imask = hwdata[NUM_MOD-1:0];
            end
            if (st_r.dp_idx == IDX_STATUS) begin
                st_nxt.flag = st_r.flag & ~hwdata[NUM_MOD-1:0];
            end
        end
        // capture and match set the sticky flag after any clear
        for (int i = 0; i < NUM_MOD; i++) begin
            if (cap_evt[i]) begin
                st_nxt.cap[i] = st_r.cnt;
            end
            if (cap_evt[i] || match_evt[i]) begin
                st_nxt.flag[i] = 1'b1;
            end
        end
        // address phase: latch writes, read after this cycle's updates
        st_nxt.dp_wr = addr_ok && hwrite;
        if (addr_ok) begin
            st_nxt.dp_idx = a_idx;
        end
        if (addr_ok && !hwrite) begin
            st_nxt.rdata = rd_word(st_nxt, a_idx);
        end
        // both the global mask and the per-module mask must allow it
        st_nxt.irq = |(st_nxt.flag & st_nxt.imask &
                       {st_nxt.mode[2][BIT_IMASK], st_nxt.mode[1][BIT_IMASK],
                        st_nxt.mode[0][BIT_IMASK]});
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata = st_r.rdata;
    assign hreadyout = st_r.ready;
    assign hresp = HRESP_OKAY;
    assign irq = st_r.irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_mode0_wr;
        addr_ok && hwrite && a_idx == IDX_MODE[0] ##1 1'b1;
    endsequence

    chk_irq_level: assert property (
        irq == |(st_r.flag & st_r.imask & mod_imask))
        else $error("interrupt level does not follow masked flags");
    chk_match_flag: assert property (
        match_evt[0] |=> st_r.flag[0])
        else $error("match did not set the event flag");
    chk_match_gate: assert property (
        st_r.run && st_r.cnt == st_r.cmp[0] &&
        st_r.mode[0][BIT_CMP_EN] && st_r.mode[0][BIT_MATCH]
        |-> match_evt[0])
        else $error("enabled match not reported");
    chk_mode_write: assert property (
        s_mode0_wr |=> st_r.mode[0] == $past(hwdata[MODE_W-1:0]))
        else $error("mode register write lost");
    chk_capture_value: assert property (
        cap_evt[1] |=> st_r.cap[1] == $past(st_r.cnt))
        else $error("captured value is not the counter");

    // software clear of flag 0 with no event in the same cycle
    sequence s_clr0_quiet;
        st_r.dp_wr && st_r.dp_idx == IDX_STATUS && hwdata[0] &&
        !cap_evt[0] && !match_evt[0];
    endsequence

    // software clear of flag 0 meeting an event: the event must win
    sequence s_clr0_event;
        st_r.dp_wr && st_r.dp_idx == IDX_STATUS && hwdata[0] &&
        (cap_evt[0] || match_evt[0]);
    endsequence

    // frequency output on module 2 at a low-byte match
    sequence s_freq2_hit;
        st_r.mode[2][BIT_CMP_EN] && st_r.mode[2][BIT_TOGGLE] &&
        st_r.mode[2][BIT_MOD] && st_r.run &&
        st_r.cnt[7:0] == st_r.cmp[2][7:0];
    endsequence

    // counter stopped and not being written
    sequence s_stopped;
        !st_r.run && !st_r.dp_wr;
    endsequence

    // a write of one clears the sticky flag
    chk_flag_clear: assert property (
        s_clr0_quiet |=> !st_r.flag[0])
        else $error("write of one did not clear the event flag");

    // a clear must never swallow an event of the same cycle
    chk_set_wins: assert property (
        s_clr0_event |=> st_r.flag[0])
        else $error("clear in the event cycle lost the event");

    // flags are sticky until software clears them
    chk_flag_sticky: assert property (
        st_r.flag[1] && !(st_r.dp_wr && st_r.dp_idx == IDX_STATUS)
        |=> st_r.flag[1])
        else $error("event flag dropped without a clear");

    // a capture edge raises the module flag
    chk_capture_flag: assert property (
        cap_evt[1] |=> st_r.flag[1])
        else $error("capture edge did not set the event flag");

    // no match is reported while the comparator is off
    chk_match_off: assert property (
        !st_r.mode[0][BIT_CMP_EN] |-> !match_evt[0])
        else $error("disabled comparator reported a match");

    // frequency output inverts the pin on every low-byte match
    chk_freq_toggle: assert property (
        s_freq2_hit |=> module_io_pin_o[2] != $past(module_io_pin_o[2]))
        else $error("frequency output did not invert on a match");

    // an unmasked flag must reach the interrupt line
    chk_irq_unmasked: assert property (
        st_r.flag[0] && st_r.imask[0] && st_r.mode[0][BIT_IMASK] |-> irq)
        else $error("unmasked event flag raised no interrupt");

    // with every module mask bit clear the line stays low
    chk_irq_masked: assert property (
        !st_r.mode[0][BIT_IMASK] && !st_r.mode[1][BIT_IMASK] &&
        !st_r.mode[2][BIT_IMASK] |-> !irq)
        else $error("interrupt raised with every module masked");

    // with the global mask clear the line stays low
    chk_mask_global: assert property (
        st_r.imask == '0 |-> !irq)
        else $error("interrupt raised with the global mask clear");

    // a disabled comparator releases its pin
    chk_oe_off: assert property (
        !st_r.mode[1][BIT_CMP_EN] |=> !module_io_pin_oe[1])
        else $error("disabled comparator still drives its pin");

    // a disabled comparator keeps its pin level frozen
    chk_pin_freeze: assert property (
        !st_r.mode[2][BIT_CMP_EN] |=> $stable(module_io_pin_o[2]))
        else $error("disabled comparator changed its pin level");

    // a running counter advances one step per clock
    chk_count_step: assert property (
        st_r.run && !st_r.dp_wr |=> st_r.cnt == $past(st_r.cnt) + CNT_W'(1))
        else $error("counter did not advance by one");

    // a stopped counter holds, so no new match can appear
    chk_count_hold: assert property (
        s_stopped |=> st_r.cnt == $past(st_r.cnt))
        else $error("stopped counter moved");
endmodule

// ### cam_pin_model.sv
// far-side model of the three module pins: a pulled-up line per module
// that the bench may drive when the design is not driving it
`timescale 1ns/100ps
module cam_pin_model
    import cam_pkg::*;
(
    input wire logic [NUM_MOD-1:0] pin_o, // design drive levels
    input wire logic [NUM_MOD-1:0] pin_oe, // design drive enables
    input wire logic [NUM_MOD-1:0] ext_drive, // bench drives the line
    input wire logic [NUM_MOD-1:0] ext_level, // bench drive level
    output logic [NUM_MOD-1:0] pin_i // resolved line levels
);
    // design drive wins; an undriven line floats up to the pull-up level,
    // so a released line never keeps showing its last driven value
    always_comb begin
        for (int k = 0; k < NUM_MOD; k++) begin
            if (pin_oe[k]) begin
                pin_i[k] = pin_o[k];
            end else if (ext_drive[k]) begin
                pin_i[k] = ext_level[k];
            end else begin
                pin_i[k] = 1'b1;
            end
        end
    end
endmodule

// ### tb_counter_array_module_mode_control.sv
// self-checking bench for the counter array mode block over AHB-Lite
// assumes a zero-wait slave with hready tied back from hreadyout
`timescale 1ns/100ps
module tb_counter_array_module_mode_control;
    import cam_pkg::*;
    logic hclk, hresetn, hwrite, dph_rd, irq, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [1:0] htrans, hresp;
    logic [NUM_MOD-1:0] pin_i, pin_o, pin_oe, ext_drive, ext_level;
    logic [31:0] exq[$];
    int num_errors = 0;
    int cmp_count = 0;
    cam_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .module_io_pin_i(pin_i),
        .module_io_pin_o(pin_o), .module_io_pin_oe(pin_oe), .irq(irq));
    cam_pin_model i_pins (.pin_o(pin_o), .pin_oe(pin_oe),
        .ext_drive(ext_drive), .ext_level(ext_level), .pin_i(pin_i));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // one single word transfer; the address phase is held until hready
    task automatic bus(input logic w, input logic [IDX_W-1:0] idx,
                       input logic [31:0] d);
        haddr <= {20'h00000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0000_0000;
        dph_rd <= ~w;
        if (!w) exq.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        dph_rd <= 1'b0;
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        bus(1'b0, idx, d);
    endtask
    // read data is judged at the edge that closes the data phase
    always @(posedge hclk) begin
        if (dph_rd === 1'b1 && hreadyout === 1'b1 && exq.size() > 0) begin
            chk(hrdata, exq.pop_front());
            chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
        end
    end
    // run the counter for n+2 cycles from a known start, then stop it
    task automatic run_for(input logic [15:0] start, input int n);
        wr(IDX_COUNT, {16'h0000, start});
        wr(IDX_CTRL, 32'h0000_0001);
        repeat (n) @(posedge hclk);
        wr(IDX_CTRL, 32'h0000_0000);
    endtask
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    initial begin
        logic [31:0] v;
        hresetn = 1'b0;
        haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0;
        dph_rd = 1'b0; ext_drive = '0; ext_level = '0; seed = 32'd18937;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, random readback, then modes cleared again
        for (int k = 0; k < NUM_MOD; k++) begin
            rd(IDX_MODE[k], {24'h0, MODE_RST});
            v = xs() & 32'h0000_00FF;
            wr(IDX_MODE[k], v);
            rd(IDX_MODE[k], v);
            wr(IDX_MODE[k], 32'h0000_0000);
        end
        rd(10'h3FF, 32'h0000_0000);
        // random modes may have caught edges of their own pin drive
        wr(IDX_STATUS, 32'h0000_0007);
        // match with toggle and unmasked interrupt on module 0
        wr(IDX_IMASK, 32'h0000_0007);
        wr(IDX_CMP[0], 32'h0000_0005);
        wr(IDX_MODE[0], 32'h0000_004D);
        run_for(16'h0000, 12);
        chk({31'h0, irq}, 32'h1);
        chk({29'h0, pin_oe}, 32'h1);
        chk({29'h0, pin_o}, 32'h1);
        rd(IDX_STATUS, 32'h0000_0001);
        wr(IDX_STATUS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        // mask bit clear: flag still sets, pin toggles back, no request
        wr(IDX_MODE[0], 32'h0000_004C);
        run_for(16'h0000, 12);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, pin_o[0]}, 32'h0);
        rd(IDX_STATUS, 32'h0000_0001);
        wr(IDX_STATUS, 32'h0000_0001);
        // comparator off: no match, pin released
        wr(IDX_MODE[0], 32'h0000_000C);
        run_for(16'h0000, 12);
        rd(IDX_STATUS, 32'h0000_0000);
        chk({31'h0, pin_oe[0]}, 32'h0);
        // 8-bit against 16-bit modulation on a stopped counter
        wr(IDX_CMP[0], 32'h0000_0020);
        wr(IDX_COUNT, 32'h0000_0110);
        wr(IDX_MODE[0], 32'h0000_0042);
        repeat (3) @(posedge hclk);
        chk({30'h0, pin_oe[0], pin_o[0]}, 32'h3);
        wr(IDX_MODE[0], 32'h0000_00C2);
        repeat (3) @(posedge hclk);
        chk({30'h0, pin_oe[0], pin_o[0]}, 32'h2);
        // frequency output on module 2: one low-byte match inverts the pin
        wr(IDX_CMP[2], 32'h0000_0003);
        wr(IDX_MODE[2], 32'h0000_0046);
        run_for(16'h0000, 12);
        chk({31'h0, pin_o[2]}, 32'h1);
        wr(IDX_MODE[2], 32'h0000_0000);
        // edge capture on module 1, rising then falling only
        wr(IDX_MODE[0], 32'h0000_0000);
        wr(IDX_MODE[1], 32'h0000_0020);
        wr(IDX_CTRL, 32'h0000_0001);
        ext_drive <= 3'b010;
        repeat (6) @(posedge hclk);
        ext_level <= 3'b010;
        repeat (6) @(posedge hclk);
        rd(IDX_STATUS, 32'h0000_0002);
        wr(IDX_STATUS, 32'h0000_0002);
        wr(IDX_MODE[1], 32'h0000_0010);
        ext_level <= 3'b000;
        repeat (6) @(posedge hclk);
        rd(IDX_STATUS, 32'h0000_0002);
        wr(IDX_STATUS, 32'h0000_0002);
        ext_level <= 3'b010;
        repeat (6) @(posedge hclk);
        rd(IDX_STATUS, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        finish_test();
    end
endmodule
